// ==== hdl/ffmd_top.sv ====
// freefall/motion event detector with its three registers
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/100ps
`include "ffmd_map.svh"

module ffmd_top
#(
    parameter int ACC_W = 8
)
(
    input  wire logic             ref_clk,
    input  wire logic             rst,
    input  wire logic [7:0]       addr,
    input  wire logic [7:0]       wdata,
    input  wire logic             wr_strobe,
    input  wire logic             rd_strobe,
    output logic      [7:0]       rdata,
    input  wire logic             sample_strobe,
    input  wire logic [ACC_W-1:0] accel_x,
    input  wire logic [ACC_W-1:0] accel_y,
    input  wire logic [ACC_W-1:0] accel_z,
    input  wire logic [7:0]       debounce_count_value,
    input  wire logic             low_noise,
    input  wire logic             motion_irq_enable,
    input  wire logic             motion_irq_route,
    output logic                  event_active,
    output logic                  irq_int1,
    output logic                  irq_int2
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    ffmd_pkg::ffmd_state_t state;
    ffmd_pkg::ffmd_state_t next_state;

    logic [ACC_W-1:0] accel [3];
    logic [2:0]       axis_high;
    logic [2:0]       axis_negative;
    logic [6:0]       eff_threshold;

    assign accel[0] = accel_x;
    assign accel[1] = accel_y;
    assign accel[2] = accel_z;

    // threshold clamp in low-noise operation
    assign eff_threshold = (low_noise && state.threshold_field > `FFMD_LOW_NOISE_MAX)
                         ? `FFMD_LOW_NOISE_MAX : state.threshold_field;

    // ----------------------------------------------------------------
    // per-axis magnitude compare
    // ----------------------------------------------------------------
    // samples arrive in threshold units, 0.063 g per count, whatever range
    genvar g;
    generate
        for (g = 0; g < 3; g++)
        begin : gen_axis
            logic [ACC_W-1:0] mag;
            assign mag = accel[g][ACC_W-1] ? ACC_W'(-accel[g]) : accel[g];
            // strictly above is high-g; at or below is low-g
            assign axis_high[g] = mag > ACC_W'(eff_threshold);
            assign axis_negative[g] = accel[g][ACC_W-1];
        end
    endgenerate

    // ----------------------------------------------------------------
    // next-state logic
    // ----------------------------------------------------------------
    always_comb
    begin
        logic       cond;
        logic       src_clear;
        logic [7:0] cnt;
        logic [7:0] src_byte;
        logic [7:0] cfg_byte;
        logic [7:0] ths_byte;

        next_state = state;
        cond       = 1'b0;
        src_clear  = 1'b0;
        cnt        = state.debounce_cnt;

        cfg_byte = {state.latch_enable, state.combine_select, state.axis_enable,
                    3'b000};
        src_byte = {state.event_active, 1'b0,
                    state.axis_event[2], state.axis_polarity[2],
                    state.axis_event[1], state.axis_polarity[1],
                    state.axis_event[0], state.axis_polarity[0]};
        ths_byte = {state.debounce_clear_mode, state.threshold_field};

        // register reads: data in the cycle after the strobe
        next_state.rdata = `FFMD_RST_BYTE;
        if (rd_strobe)
        begin
            unique case (addr)
                `FFMD_ADDR_CONFIG:    next_state.rdata = cfg_byte;
                `FFMD_ADDR_SOURCE:    next_state.rdata = src_byte;
                `FFMD_ADDR_THRESHOLD: next_state.rdata = ths_byte;
                default:              next_state.rdata = `FFMD_RST_BYTE;
            endcase
        end

        // register writes
        if (wr_strobe && addr == `FFMD_ADDR_CONFIG)
        begin
            next_state.latch_enable   = wdata[`FFMD_CFG_LATCH_BIT];
            next_state.combine_select = wdata[`FFMD_CFG_COMBINE_BIT];
            next_state.axis_enable    = wdata[`FFMD_CFG_Z_EN_BIT:`FFMD_CFG_X_EN_BIT];
        end
        if (wr_strobe && addr == `FFMD_ADDR_THRESHOLD)
        begin
            next_state.debounce_clear_mode = wdata[`FFMD_THS_MODE_BIT];
            next_state.threshold_field     = wdata[`FFMD_THS_MSB:0];
        end

        // latched source read clears the event flag, axis flags and counter; a set in the same cycle wins below
        src_clear = rd_strobe && addr == `FFMD_ADDR_SOURCE && state.latch_enable;
        if (src_clear)
        begin
            next_state.event_active  = 1'b0;
            next_state.axis_event    = 3'b000;
            next_state.axis_polarity = 3'b000;
            cnt                      = 8'h00;
        end

        // combination of enabled axes; no axes enabled disables the block
        if (state.combine_select)
            cond = |(state.axis_enable & axis_high);
        else
            cond = (|state.axis_enable) && &(~state.axis_enable | ~axis_high);

        if (sample_strobe)
        begin
            // debounce counter
            if (cond)
            begin
                if (cnt < debounce_count_value)
                    cnt = cnt + 8'h01;
                else
                    cnt = debounce_count_value;
            end
            else if (state.debounce_clear_mode)
                cnt = 8'h00;
            else if (cnt != 8'h00)
                cnt = cnt - 8'h01;

            // event-active flag
            if (cond && cnt == debounce_count_value)
                next_state.event_active = 1'b1;
            else if (!state.latch_enable && !cond
                     && (state.debounce_clear_mode || cnt == 8'h00))
                next_state.event_active = 1'b0;

            // axis flags: live while the event is clear or not latched
            if (!(state.latch_enable && state.event_active) || src_clear)
            begin
                next_state.axis_event    = state.axis_enable & axis_high;
                next_state.axis_polarity = state.axis_enable & axis_negative;
            end
        end

        // flags of an axis that was just disabled read zero at once
        next_state.axis_event    = next_state.axis_event & next_state.axis_enable;
        next_state.axis_polarity = next_state.axis_polarity & next_state.axis_enable;

        // a lowered target pulls the counter down with it
        if (cnt > debounce_count_value)
            cnt = debounce_count_value;

        next_state.debounce_cnt = cnt;

        // interrupt: route 1 to first line, 0 to second
        next_state.irq_int1 = next_state.event_active && motion_irq_enable
                              && motion_irq_route;
        next_state.irq_int2 = next_state.event_active && motion_irq_enable
                              && !motion_irq_route;
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            state.latch_enable        <= 1'b0;
            state.combine_select      <= 1'b0;
            state.axis_enable         <= 3'b000;
            state.debounce_clear_mode <= 1'b0;
            state.threshold_field     <= `FFMD_RST_THS;
            state.debounce_cnt        <= `FFMD_RST_BYTE;
            state.event_active        <= 1'b0;
            state.axis_event          <= 3'b000;
            state.axis_polarity       <= 3'b000;
            state.rdata               <= `FFMD_RST_BYTE;
            state.irq_int1            <= 1'b0;
            state.irq_int2            <= 1'b0;
        end
        else
        begin
            state <= next_state;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign rdata        = state.rdata;
    assign event_active = state.event_active;
    assign irq_int1     = state.irq_int1;
    assign irq_int2     = state.irq_int2;

endmodule

// ==== pkg/ffmd_map.svh ====
// register map, field positions and reset values of the freefall/motion detector
`ifndef FFMD_MAP_SVH
`define FFMD_MAP_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define FFMD_ADDR_CONFIG     8'h15
`define FFMD_ADDR_SOURCE     8'h16
`define FFMD_ADDR_THRESHOLD  8'h17

// ----------------------------------------------------------------
// configuration fields
// ----------------------------------------------------------------
`define FFMD_CFG_LATCH_BIT   7
`define FFMD_CFG_COMBINE_BIT 6
`define FFMD_CFG_Z_EN_BIT    5
`define FFMD_CFG_Y_EN_BIT    4
`define FFMD_CFG_X_EN_BIT    3

// ----------------------------------------------------------------
// source and threshold fields
// ----------------------------------------------------------------
`define FFMD_SRC_EVENT_BIT   7
`define FFMD_THS_MODE_BIT    7
`define FFMD_THS_MSB         6

// ----------------------------------------------------------------
// reset values and limits
// ----------------------------------------------------------------
`define FFMD_RST_BYTE        8'h00
`define FFMD_RST_THS         7'h00
`define FFMD_LOW_NOISE_MAX   7'h3f

`endif

// ==== pkg/ffmd_pkg.sv ====
// types of the freefall/motion detector
package ffmd_pkg;

    typedef struct packed {
        logic       latch_enable;
        logic       combine_select;
        logic [2:0] axis_enable;
        logic       debounce_clear_mode;
        logic [6:0] threshold_field;
        logic [7:0] debounce_cnt;
        logic       event_active;
        logic [2:0] axis_event;
        logic [2:0] axis_polarity;
        logic [7:0] rdata;
        logic       irq_int1;
        logic       irq_int2;
    } ffmd_state_t;

endpackage

// ==== bench/ffmd_asserts.sv ====
// port assertions of the freefall/motion detector
`timescale 1ns/100ps
module ffmd_asserts
(
    input wire logic       ref_clk,
    input wire logic       rst,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       wr_strobe,
    input wire logic       rd_strobe,
    input wire logic [7:0] rdata,
    input wire logic       sample_strobe,
    input wire logic       motion_irq_enable,
    input wire logic       motion_irq_route,
    input wire logic       event_active,
    input wire logic       irq_int1,
    input wire logic       irq_int2
);
    logic latch_on;
    logic src_rd;
    logic quiet;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    assign src_rd = rd_strobe && addr == 8'h16;
    assign quiet  = !sample_strobe && !wr_strobe;
    // shadow of the latch enable bit
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            latch_on <= 1'h0;
        else if (wr_strobe && addr == 8'h15)
            latch_on <= wdata[7];
    end
    property p_cfg_low;
        $past(rd_strobe) && $past(addr) == 8'h15 |-> rdata[2:0] == 3'h0;
    endproperty
    a_cfg_low: assert property (p_cfg_low) else $error("config low bits");
    property p_src_form;
        $past(src_rd) |-> rdata[6] == 1'h0 && rdata[7] == $past(event_active);
    endproperty
    a_src_form: assert property (p_src_form) else $error("source layout");
    property p_irq1;
        irq_int1 == (event_active && $past(motion_irq_enable) && $past(motion_irq_route));
    endproperty
    a_irq1: assert property (p_irq1) else $error("irq_int1 gating");
    property p_irq2;
        irq_int2 == (event_active && $past(motion_irq_enable) && !$past(motion_irq_route));
    endproperty
    a_irq2: assert property (p_irq2) else $error("irq_int2 gating");
    property p_rise;
        $rose(event_active) |-> $past(sample_strobe);
    endproperty
    a_rise: assert property (p_rise) else $error("event without sample");
    property p_idle;
        quiet && !rd_strobe |=> $stable(event_active);
    endproperty
    a_idle: assert property (p_idle) else $error("event moved while idle");
    property p_hold;
        latch_on && event_active && !wr_strobe && !src_rd |=> event_active;
    endproperty
    a_hold: assert property (p_hold) else $error("latched event lost");
    property p_clear;
        latch_on && event_active && src_rd && quiet |=> !event_active;
    endproperty
    a_clear: assert property (p_clear) else $error("read did not clear");
    property p_nl_read;
        !latch_on && src_rd && quiet |=> $stable(event_active);
    endproperty
    a_nl_read: assert property (p_nl_read) else $error("read changed event");
    c_clear: cover property (latch_on && event_active && src_rd);
    c_irq1: cover property ($rose(irq_int1));
    c_irq2: cover property ($rose(irq_int2));
endmodule
bind ffmd_top ffmd_asserts chk_u (.ref_clk, .rst, .addr, .wdata, .wr_strobe, .rd_strobe,
    .rdata, .sample_strobe, .motion_irq_enable, .motion_irq_route, .event_active,
    .irq_int1, .irq_int2);

// ==== bench/tb.sv ====
// self-checking bench of the freefall/motion detector
`timescale 1ns/100ps
module tb;
    logic       ref_clk = 1'h0;
    logic       rst = 1'h1;
    logic [7:0] addr = 8'h00, wdata = 8'h00, ax = 8'h00, ay = 8'h00, az = 8'h00;
    logic [7:0] dbc = 8'h00, rdata;
    logic       wr = 1'h0, rd = 1'h0, smp_s = 1'h0, lown = 1'h0, ien = 1'h0, irt = 1'h0;
    logic       event_active, irq_int1, irq_int2;
    int         n_mismatch = 0, n_checks = 0, cycles = 0;
    ffmd_top dut_u (.ref_clk(ref_clk), .rst(rst), .addr(addr), .wdata(wdata),
        .wr_strobe(wr), .rd_strobe(rd), .rdata(rdata), .sample_strobe(smp_s),
        .accel_x(ax), .accel_y(ay), .accel_z(az), .debounce_count_value(dbc),
        .low_noise(lown), .motion_irq_enable(ien), .motion_irq_route(irt),
        .event_active(event_active), .irq_int1(irq_int1), .irq_int2(irq_int2));
    always #4 ref_clk = ~ref_clk;
    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            n_mismatch++;
            end_sim;
        end
    end
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wrr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'h1;
        @(posedge ref_clk);
        wr    <= 1'h0;
    endtask
    task automatic rdr(input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        addr <= a;
        rd   <= 1'h1;
        @(posedge ref_clk);
        rd   <= 1'h0;
        @(negedge ref_clk);
        chk("rdata", exp, rdata);
    endtask
    task automatic smp(input logic [7:0] x, input logic [7:0] y, input logic [7:0] z);
        @(posedge ref_clk);
        ax    <= x;
        ay    <= y;
        az    <= z;
        smp_s <= 1'h1;
        @(posedge ref_clk);
        smp_s <= 1'h0;
        @(negedge ref_clk);
    endtask
    task automatic evt(input logic e);
        chk("event_active", {7'h0, e}, {7'h0, event_active});
    endtask
    task automatic t_regs;
        rdr(8'h15, 8'h00);
        rdr(8'h16, 8'h00);
        rdr(8'h17, 8'h00);
        wrr(8'h15, 8'hff);
        wrr(8'h17, 8'hff);
        wrr(8'h18, 8'hff);
        rdr(8'h15, 8'hf8);
        rdr(8'h17, 8'hff);
        rdr(8'h18, 8'h00);
    endtask
    task automatic t_motion_latch;
        @(posedge ref_clk);
        dbc <= 8'h02;
        ien <= 1'h1;
        irt <= 1'h1;
        wrr(8'h15, 8'he8);
        wrr(8'h17, 8'h0a);
        smp(8'h0a, 8'h64, 8'h00);
        rdr(8'h16, 8'h00);
        smp(8'h14, 8'h64, 8'h00);
        rdr(8'h16, 8'h02);
        smp(8'h14, 8'h00, 8'h00);
        evt(1'h0);
        smp(8'h14, 8'h00, 8'h00);
        evt(1'h1);
        chk("irq_int1", 8'h01, {7'h0, irq_int1});
        smp(8'hec, 8'h00, 8'h9c);
        rdr(8'h16, 8'h82);
        evt(1'h0);
        smp(8'hec, 8'h00, 8'h00);
        evt(1'h0);
        rdr(8'h16, 8'h03);
    endtask
    task automatic t_debounce;
        @(posedge ref_clk);
        irt <= 1'h0;
        wrr(8'h15, 8'h38);
        for (int m = 0; m < 2; m++)
        begin
            wrr(8'h17, {m[0], 7'h0a});
            for (int i = 0; i < 6; i++)
            begin
                smp(6'b001011 >> i & 1 ? 8'h0a : 8'h0b, 8'h00, 8'hf6);
                evt(1'((m ? 6'b000010 : 6'b011110) >> i));
                if (i == 1)
                begin
                    chk("irq_int2", 8'h01, {7'h0, irq_int2});
                    rdr(8'h16, 8'h90);
                end
            end
        end
    endtask
    task automatic t_low_noise;
        @(posedge ref_clk);
        lown <= 1'h1;
        dbc  <= 8'h00;
        wrr(8'h15, 8'h48);
        wrr(8'h17, 8'h7f);
        smp(8'h40, 8'h00, 8'h00);
        rdr(8'h16, 8'h82);
        @(posedge ref_clk);
        lown <= 1'h0;
        smp(8'h40, 8'h00, 8'h00);
        rdr(8'h16, 8'h00);
    endtask
    task automatic t_reset;
        smp(8'h80, 8'h00, 8'h00);
        rdr(8'h16, 8'h83);
        chk("irq_int2", 8'h01, {7'h0, irq_int2});
        @(posedge ref_clk);
        rst <= 1'h1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'h0;
        @(negedge ref_clk);
        evt(1'h0);
        chk("irq_int2", 8'h00, {7'h0, irq_int2});
        rdr(8'h15, 8'h00);
        rdr(8'h16, 8'h00);
        rdr(8'h17, 8'h00);
    endtask
    initial
    begin
        repeat (10) @(posedge ref_clk);
        rst <= 1'h0;
        t_regs;
        t_motion_latch;
        t_debounce;
        t_low_noise;
        t_reset;
        end_sim;
    end
endmodule
